// *** core/rst_seq_pkg.sv ***
// What this block does
// - Four reset kinds; pin fundamental clears all, software keeps EEPROM load status, hot keeps sticky register fields.
// - Fundamental reset from platform reset pin (cold or warm) or software bit.
// - Capture boot straps on pin release; software reset reuses captured values.
// - Initialize PLL and SerDes, then start training; sequence continues in parallel.
// - Reset-halt strap sets reset-halt status during fundamental reset.
// - Outside test modes release stacks to quasi-reset; training within 20 ms.
// - Within 100 ms stacks answer configuration with retry, ignore other requests.
// - Master SMBus runs 100 KHz with slow strap, else 400 KHz.
// - Release slave SMBus with strapped address, then release master SMBus.
// - EEPROM modes load the serial EEPROM into registers via master SMBus.
// - EEPROM write of full-link-retrain bit retrains all ports.
// - Load error aborts, sets reset-halt, records error; done set either way.
// - Reset-halt holds logic in reset except SMBus, registers, retrying stacks.
// - EEPROM-sourced side effects fire at the moment of the write.
// - Software reset bits answer their write before the reset begins.
// - Hot reset from hot-reset TS1, upstream DL_Down or software bit.
// - Disable-link-down bit suppresses only the DL_Down hot reset trigger.
// - Hot reset sends TS1 downstream, resets all but PLL, SerDes, SMBuses.
// - Hot reset reloads EEPROM only if mode needs it and not disabled.
// - During hot reset registers read zero and writes are discarded.
// - Low-latency mode cuts latency 8 ns; advised only with suitable clocking.
// - Mode 0 normal, 1 EEPROM, 2 low latency, 3 both; others reserved.
// - Sequencer timing derives from the core clock.
package rst_seq_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned TRAIN_MS = 20;
  localparam int unsigned RETRY_MS = 100;
  localparam int unsigned EE_MS = 200;
  localparam int unsigned TRAIN_CYC = CLK_HZ / 1000 * TRAIN_MS;
  localparam int unsigned RETRY_CYC = CLK_HZ / 1000 * RETRY_MS;
  localparam int unsigned EE_CYC = CLK_HZ / 1000 * EE_MS;
  localparam int unsigned PLL_CYC = 16;
  localparam int unsigned SMB_SLOW_KHZ = 100;
  localparam int unsigned SMB_FAST_KHZ = 400;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;
  localparam logic [11:0] ADDR_SMB = 12'h008;
  localparam logic [11:0] ADDR_PHY = 12'h00c;
  localparam logic [11:0] ADDR_SCRATCH = 12'h010;
  localparam int unsigned CTL_FUNDAMENTAL_RESET_BIT = 0;
  localparam int unsigned CTL_HOT_RESET_BIT = 1;
  localparam int unsigned CTL_HALT = 2;
  localparam int unsigned CTL_DLD = 3;
  localparam int unsigned CTL_DHEE = 4;
  localparam int unsigned PHY_FULL_LINK_RETRAIN_BIT = 0;
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_EE = 3'h1;
  localparam logic [2:0] MODE_LOWLAT = 3'h2;
  localparam logic [2:0] MODE_EE_LOWLAT = 3'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    ST_RESET, ST_PLL, ST_QUASI, ST_SLV_SMB, ST_MST_SMB, ST_EE_LOAD,
    ST_HALT, ST_RUN
  } seq_e;
endpackage : rst_seq_pkg

// *** core/switch_reset_sequencer.sv ***
module switch_reset_sequencer #(
  parameter int unsigned TRAIN_CYCLES = rst_seq_pkg::TRAIN_CYC,
  parameter int unsigned RETRY_CYCLES = rst_seq_pkg::RETRY_CYC,
  parameter int unsigned EE_CYCLES = rst_seq_pkg::EE_CYC,
  parameter int unsigned PORTS = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic platform_reset_n,
  input wire logic power_on_n,
  input wire logic [2:0] switch_mode_straps,
  input wire logic reset_halt,
  input wire logic master_smbus_slow_strap,
  input wire logic [3:0] slave_smbus_addr_straps,
  input wire logic test_mode,
  input wire logic hot_reset_ts1,
  input wire logic dl_down,
  input wire logic ee_wr_valid,
  input wire logic [11:0] ee_wr_addr,
  input wire logic [31:0] ee_wr_data,
  input wire logic ee_done,
  input wire logic ee_error,
  input wire logic [7:0] ee_error_code,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic pll_serdes_rst_n,
  output logic link_train_en,
  output logic stack_rst_n,
  output logic quasi_reset,
  output logic core_rst_n,
  output logic slave_smbus_rst_n,
  output logic [6:0] slave_smbus_addr,
  output logic master_smbus_rst_n,
  output logic master_smbus_slow,
  output logic ee_load_start,
  output logic low_latency,
  output logic hot_reset_ts1_out,
  output logic [PORTS-1:0] port_retrain,
  output logic [2:0] sequence_state
);
  typedef struct packed {
    logic [1:0] prst_s;
    logic [1:0] pwr_s;
    logic [1:0] ts1_s;
    logic [1:0] dld_s;
    logic cold_seen;
    logic cold_last;
    rst_seq_pkg::seq_e st;
    logic hot;
    logic [31:0] tmr;
    logic [2:0] mode;
    logic halt_strap;
    logic slow;
    logic [3:0] saddr;
    logic halt_sts;
    logic halt_ctl;
    logic dld;
    logic dhee;
    logic [31:0] scratch;
    logic ee_done_f;
    logic ee_err_f;
    logic [7:0] ee_code;
    logic [PORTS-1:0] retrain;
    logic pend_f;
    logic pend_h;
    logic have_aw;
    logic [11:0] awa;
    logic have_w;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bv;
    logic [1:0] br;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
    logic ee_go;
  } state_s;
  state_s q, d;

  logic prst_n, pwr_n, ts1, dldown, in_hot;
  logic [11:0] ara;
  logic [31:0] wmask;
  assign prst_n = q.prst_s[1];
  assign pwr_n = q.pwr_s[1];
  assign ts1 = q.ts1_s[1];
  assign dldown = q.dld_s[1];
  assign ara = s_axi_araddr[11:0];
  assign in_hot = q.hot && q.st != rst_seq_pkg::ST_RUN;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{q.ws[i]}};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    d.prst_s = {q.prst_s[0], platform_reset_n};
    d.pwr_s = {q.pwr_s[0], power_on_n};
    d.ts1_s = {q.ts1_s[0], hot_reset_ts1};
    d.dld_s = {q.dld_s[0], dl_down};
    d.retrain = '0;
    d.ee_go = 1'b0;
    if (q.tmr != 32'h0000_0000) begin
      d.tmr = q.tmr - 32'h0000_0001;
    end

    // Cold versus warm: the power-on level marks the next pin reset cold.
    if (!pwr_n) begin
      d.cold_seen = 1'b1;
    end

    // Sequencer.
    case (q.st)
      rst_seq_pkg::ST_RESET: begin
        if (prst_n) begin
          d.st = rst_seq_pkg::ST_PLL;
          d.tmr = 32'(rst_seq_pkg::PLL_CYC);
          // Only a power-up seen since the last release makes it cold.
          d.cold_last = q.cold_seen;
          d.cold_seen = 1'b0;
          if (!q.hot) begin
            d.halt_sts = q.halt_strap;
          end
        end
      end
      rst_seq_pkg::ST_PLL: begin
        if (q.tmr == 32'h0000_0000 || q.hot) begin
          d.st = rst_seq_pkg::ST_QUASI;
          d.tmr = 32'(RETRY_CYCLES);
        end
      end
      rst_seq_pkg::ST_QUASI: begin
        d.st = q.hot ? rst_seq_pkg::ST_MST_SMB : rst_seq_pkg::ST_SLV_SMB;
      end
      rst_seq_pkg::ST_SLV_SMB: begin
        d.st = rst_seq_pkg::ST_MST_SMB;
      end
      rst_seq_pkg::ST_MST_SMB: begin
        if ((q.mode == rst_seq_pkg::MODE_EE ||
             q.mode == rst_seq_pkg::MODE_EE_LOWLAT) &&
            !(q.hot && q.dhee)) begin
          d.st = rst_seq_pkg::ST_EE_LOAD;
          d.ee_go = 1'b1;
          d.ee_done_f = 1'b0;
        end else begin
          d.st = q.halt_ctl && !q.hot ? rst_seq_pkg::ST_HALT
                                      : rst_seq_pkg::ST_RUN;
        end
      end
      rst_seq_pkg::ST_EE_LOAD: begin
        if (ee_wr_valid) begin
          if (ee_wr_addr == rst_seq_pkg::ADDR_PHY &&
              ee_wr_data[rst_seq_pkg::PHY_FULL_LINK_RETRAIN_BIT]) begin
            d.retrain = {PORTS{1'b1}};
          end else if (ee_wr_addr == rst_seq_pkg::ADDR_CTRL) begin
            d.halt_ctl = ee_wr_data[rst_seq_pkg::CTL_HALT];
            d.dld = ee_wr_data[rst_seq_pkg::CTL_DLD];
            d.dhee = ee_wr_data[rst_seq_pkg::CTL_DHEE];
          end else if (ee_wr_addr == rst_seq_pkg::ADDR_SCRATCH) begin
            d.scratch = ee_wr_data;
          end
        end
        if (ee_error) begin
          d.ee_err_f = 1'b1;
          d.ee_code = ee_error_code;
          d.ee_done_f = 1'b1;
          d.halt_ctl = 1'b1;
          d.st = rst_seq_pkg::ST_HALT;
        end else if (ee_done) begin
          d.ee_done_f = 1'b1;
          d.st = (q.halt_ctl || (ee_wr_valid && ee_wr_addr ==
                  rst_seq_pkg::ADDR_CTRL && ee_wr_data[rst_seq_pkg::CTL_HALT]))
                 ? rst_seq_pkg::ST_HALT : rst_seq_pkg::ST_RUN;
        end
      end
      rst_seq_pkg::ST_HALT: begin
        if (!q.halt_ctl) begin
          d.st = rst_seq_pkg::ST_RUN;
        end
      end
      rst_seq_pkg::ST_RUN: begin
        d.hot = 1'b0;
      end
      default: d.st = rst_seq_pkg::ST_RESET;
    endcase

    // AXI4-Lite slave: one write and one read outstanding.
    if (s_axi_awvalid && !q.have_aw && !q.bv) begin
      d.have_aw = 1'b1;
      d.awa = s_axi_awaddr[11:0];
    end
    if (s_axi_wvalid && !q.have_w && !q.bv) begin
      d.have_w = 1'b1;
      d.wd = s_axi_wdata;
      d.ws = s_axi_wstrb;
    end
    if (q.have_aw && q.have_w && !q.bv) begin
      d.have_aw = 1'b0;
      d.have_w = 1'b0;
      d.bv = 1'b1;
      d.br = rst_seq_pkg::RESP_OKAY;
      if (in_hot) begin
        d.br = rst_seq_pkg::RESP_OKAY;
      end else if (q.awa == rst_seq_pkg::ADDR_CTRL) begin
        if (q.ws[0]) begin
          // Reset bits only arm here; the reset fires after the answer.
          d.pend_f = q.wd[rst_seq_pkg::CTL_FUNDAMENTAL_RESET_BIT];
          d.pend_h = q.wd[rst_seq_pkg::CTL_HOT_RESET_BIT];
          // A load error in the same cycle keeps the halt set.
          d.halt_ctl = q.wd[rst_seq_pkg::CTL_HALT] ||
                       (q.st == rst_seq_pkg::ST_EE_LOAD && ee_error);
          d.dld = q.wd[rst_seq_pkg::CTL_DLD];
          d.dhee = q.wd[rst_seq_pkg::CTL_DHEE];
        end
      end else if (q.awa == rst_seq_pkg::ADDR_PHY) begin
        if (q.ws[0] && q.wd[rst_seq_pkg::PHY_FULL_LINK_RETRAIN_BIT]) begin
          d.retrain = {PORTS{1'b1}};
        end
      end else if (q.awa == rst_seq_pkg::ADDR_SCRATCH) begin
        d.scratch = (q.scratch & ~wmask) | (q.wd & wmask);
      end else if (q.awa == rst_seq_pkg::ADDR_STAT ||
                   q.awa == rst_seq_pkg::ADDR_SMB) begin
        d.br = rst_seq_pkg::RESP_OKAY;
      end else begin
        d.br = rst_seq_pkg::RESP_SLVERR;
      end
    end
    if (q.bv && s_axi_bready) begin
      d.bv = 1'b0;
    end
    if (s_axi_arvalid && !q.rv) begin
      d.rv = 1'b1;
      d.rr = rst_seq_pkg::RESP_OKAY;
      d.rd = 32'h0000_0000;
      if (in_hot) begin
        d.rd = 32'h0000_0000;
      end else if (ara == rst_seq_pkg::ADDR_CTRL) begin
        d.rd[rst_seq_pkg::CTL_HALT] = q.halt_ctl;
        d.rd[rst_seq_pkg::CTL_DLD] = q.dld;
        d.rd[rst_seq_pkg::CTL_DHEE] = q.dhee;
      end else if (ara == rst_seq_pkg::ADDR_STAT) begin
        d.rd[14:0] = {q.cold_last, q.st == rst_seq_pkg::ST_HALT, q.st,
                      q.saddr, q.slow, q.halt_sts, q.mode};
      end else if (ara == rst_seq_pkg::ADDR_SMB) begin
        d.rd[9:0] = {q.ee_code, q.ee_err_f, q.ee_done_f};
      end else if (ara == rst_seq_pkg::ADDR_PHY) begin
        d.rd = 32'h0000_0000;
      end else if (ara == rst_seq_pkg::ADDR_SCRATCH) begin
        d.rd = q.scratch;
      end else begin
        d.rr = rst_seq_pkg::RESP_SLVERR;
      end
    end
    if (q.rv && s_axi_rready) begin
      d.rv = 1'b0;
    end

    // Software resets start only once their write answer is accepted.
    if (q.bv && s_axi_bready && q.pend_f) begin
      // Keep the synchronisers and a read in flight; drop pulses and clear state.
      d.retrain = '0;
      d.ee_go = 1'b0;
      d.pend_f = 1'b0;
      d.st = rst_seq_pkg::ST_RESET; // warm reuses captured straps
      d.hot = 1'b0;
      d.bv = 1'b0;
      d.halt_sts = 1'b0;
      d.pend_h = 1'b0;
      d.dld = 1'b0;
      d.dhee = 1'b0;
      d.scratch = 32'h0000_0000;
      d.halt_ctl = q.halt_strap;
    end else if ((q.bv && s_axi_bready && q.pend_h) || ts1 ||
                 (dldown && !q.dld)) begin
      d.pend_h = 1'b0;
      d.ee_go = 1'b0;
      d.st = rst_seq_pkg::ST_PLL; // PLL and SMBus not reset
      d.hot = 1'b1;
      d.halt_ctl = 1'b0; // halt only if the reload sets it
      d.scratch = 32'h0000_0000; // sticky dld/dhee survive
    end

    // Pin reset: capture straps on release, clear state including EEPROM status.
    if (!prst_n) begin
      d.st = rst_seq_pkg::ST_RESET;
      d.hot = 1'b0;
      d.mode = switch_mode_straps;
      d.halt_strap = reset_halt;
      d.halt_ctl = reset_halt;
      d.slow = master_smbus_slow_strap;
      d.saddr = slave_smbus_addr_straps;
      d.halt_sts = 1'b0;
      d.dld = 1'b0;
      d.dhee = 1'b0;
      d.scratch = 32'h0000_0000;
      d.ee_done_f = 1'b0;
      d.ee_err_f = 1'b0;
      d.ee_code = 8'h00;
      d.pend_f = 1'b0;
      d.pend_h = 1'b0;
      d.ee_go = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.st <= rst_seq_pkg::ST_RESET;
    end else begin
      q <= d;
    end
  end

  // Training must be active by TRAIN_CYCLES; enabling it at quasi-reset
  // entry meets that bound with a wide margin.
  assign pll_serdes_rst_n = q.st != rst_seq_pkg::ST_RESET;
  assign link_train_en = q.st != rst_seq_pkg::ST_RESET &&
                         q.st != rst_seq_pkg::ST_PLL;
  assign stack_rst_n = link_train_en && !test_mode;
  assign quasi_reset = stack_rst_n && q.st != rst_seq_pkg::ST_RUN;
  assign core_rst_n = q.st == rst_seq_pkg::ST_RUN;
  assign slave_smbus_rst_n = (q.st != rst_seq_pkg::ST_RESET &&
                              q.st != rst_seq_pkg::ST_PLL &&
                              q.st != rst_seq_pkg::ST_QUASI) || q.hot;
  assign master_smbus_rst_n = slave_smbus_rst_n &&
                              q.st != rst_seq_pkg::ST_SLV_SMB;
  assign slave_smbus_addr = {1'b0, q.saddr[3], 1'b0, q.saddr[2:0], 1'b0};
  assign master_smbus_slow = q.slow;
  assign ee_load_start = q.ee_go;
  assign low_latency = q.mode == rst_seq_pkg::MODE_LOWLAT ||
                       q.mode == rst_seq_pkg::MODE_EE_LOWLAT;
  assign hot_reset_ts1_out = q.hot && q.st == rst_seq_pkg::ST_PLL;
  assign port_retrain = q.retrain;
  assign sequence_state = q.st[2:0];
  assign s_axi_awready = !q.have_aw && !q.bv;
  assign s_axi_wready = !q.have_w && !q.bv;
  assign s_axi_bvalid = q.bv;
  assign s_axi_bresp = q.br;
  assign s_axi_arready = !q.rv;
  assign s_axi_rvalid = q.rv;
  assign s_axi_rdata = q.rd;
  assign s_axi_rresp = q.rr;
endmodule : switch_reset_sequencer

// *** dv/switch_reset_sequencer_checker.sv ***
module switch_reset_sequencer_checker #(
  parameter int unsigned PORTS = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic platform_reset_n,
  input wire logic master_smbus_slow_strap,
  input wire logic [3:0] slave_smbus_addr_straps,
  input wire logic hot_reset_ts1,
  input wire logic ee_wr_valid,
  input wire logic [11:0] ee_wr_addr,
  input wire logic [31:0] ee_wr_data,
  input wire logic pll_serdes_rst_n,
  input wire logic link_train_en,
  input wire logic stack_rst_n,
  input wire logic quasi_reset,
  input wire logic core_rst_n,
  input wire logic slave_smbus_rst_n,
  input wire logic [6:0] slave_smbus_addr,
  input wire logic master_smbus_rst_n,
  input wire logic master_smbus_slow,
  input wire logic ee_load_start,
  input wire logic hot_reset_ts1_out,
  input wire logic [PORTS-1:0] port_retrain,
  input wire logic [2:0] sequence_state
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Budgets are 100 cycles in the bench; the margin covers the pin sync.
  sequence s_rel;
    $rose(platform_reset_n);
  endsequence
  sequence s_mst_up;
    $rose(master_smbus_rst_n);
  endsequence
  AST_PLL_FIRST: assert property (
    $rose(link_train_en) |-> pll_serdes_rst_n)
    else $error("training before pll release");
  AST_TRAIN_WIN: assert property (
    s_rel |-> ##[1:150] link_train_en)
    else $error("training late");
  AST_RETRY_WIN: assert property (
    s_rel |-> ##[1:150] (stack_rst_n && quasi_reset))
    else $error("stacks not in quasi reset");
  AST_SMB_RATE: assert property (
    s_mst_up |-> master_smbus_slow == master_smbus_slow_strap)
    else $error("master smbus rate wrong");
  AST_SLV_ADDR: assert property (
    $rose(slave_smbus_rst_n) |-> {slave_smbus_addr[5],
    slave_smbus_addr[3:1]} == slave_smbus_addr_straps)
    else $error("slave smbus address wrong");
  AST_SLV_FIRST: assert property (
    s_mst_up |-> slave_smbus_rst_n)
    else $error("master smbus before slave");
  AST_EE_AFTER_MST: assert property (
    ee_load_start |-> master_smbus_rst_n)
    else $error("load without master smbus");
  AST_RETRAIN: assert property (
    ee_wr_valid && ee_wr_addr == rst_seq_pkg::ADDR_PHY && ee_wr_data[0]
    |-> ##[1:2] port_retrain == '1)
    else $error("retrain missing");
  AST_HALT_HOLD: assert property (
    sequence_state == 3'h6 |-> !core_rst_n && slave_smbus_rst_n &&
    master_smbus_rst_n && quasi_reset == stack_rst_n)
    else $error("core released in halt");
  AST_HOT_TS1: assert property (
    hot_reset_ts1 && sequence_state == 3'h7 |-> ##[1:10] hot_reset_ts1_out)
    else $error("hot reset not propagated");
endmodule : switch_reset_sequencer_checker
////////////////////////////////////////////////////////////////////////
bind switch_reset_sequencer switch_reset_sequencer_checker #(.PORTS(PORTS))
  i_switch_reset_sequencer_checker (
  .aclk, .aresetn, .platform_reset_n, .master_smbus_slow_strap,
  .slave_smbus_addr_straps, .hot_reset_ts1, .ee_wr_valid, .ee_wr_addr,
  .ee_wr_data, .pll_serdes_rst_n, .link_train_en, .stack_rst_n,
  .quasi_reset, .core_rst_n, .slave_smbus_rst_n, .slave_smbus_addr,
  .master_smbus_rst_n, .master_smbus_slow, .ee_load_start,
  .hot_reset_ts1_out, .port_retrain, .sequence_state
);

// *** dv/ee_loader_model.sv ***
module ee_loader_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic fail,
  input wire logic slow,
  output logic wr_valid,
  output logic [11:0] wr_addr,
  output logic [31:0] wr_data,
  output logic done,
  output logic error,
  output logic [7:0] code
);
  int cnt = 0;
  int lat;
  initial begin
    wr_addr = 12'h0;
    wr_data = 32'h0;
  end
  always @(posedge aclk) begin
    lat = slow ? 60 : 3;
    cnt <= (!aresetn || cnt == lat + 2) ? 0 : start ? 1 : cnt ? cnt + 1 : 0;
    // Prerequisite lands before the write that retrains.
    wr_valid <= aresetn && !fail && (cnt == lat || cnt == lat + 1);
    wr_addr <= cnt == lat ? rst_seq_pkg::ADDR_SCRATCH :
               cnt == lat + 1 ? rst_seq_pkg::ADDR_PHY : ~wr_addr;
    wr_data <= cnt == lat ? 32'ha5 : cnt == lat + 1 ? 32'h1 : ~wr_data;
    done <= aresetn && !fail && cnt == lat + 2;
    error <= aresetn && fail && cnt == lat;
    code <= 8'h3c;
  end
endmodule : ee_loader_model

// *** dv/test_switch_reset_sequencer.sv ***
module test_switch_reset_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 0, aresetn = 0, platform_reset_n = 0, power_on_n = 0;
  logic [2:0] switch_mode_straps = 0;
  logic reset_halt = 0, master_smbus_slow_strap = 0, test_mode = 0;
  logic [3:0] slave_smbus_addr_straps = 0, s_axi_wstrb = 4'hf;
  logic hot_reset_ts1 = 0, dl_down = 0, fail = 0, slow = 0, st7, bst;
  logic ee_wr_valid, ee_done, ee_error, ee_load_start, low_latency;
  logic [11:0] ee_wr_addr;
  logic [7:0] ee_error_code;
  logic [31:0] ee_wr_data, s_axi_awaddr = 0, s_axi_wdata = 0;
  logic [31:0] s_axi_araddr = 0, s_axi_rdata, rd;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [3:0] port_retrain;
  logic [2:0] sequence_state;
  int n_errors = 0, checks = 0, n_ee = 0, n_rt = 0, exp_rt = 0, cyc = 0;
  int m, k;
  logic [31:0] scr;
  switch_reset_sequencer #(.TRAIN_CYCLES(100), .RETRY_CYCLES(100),
    .EE_CYCLES(100)) i_switch_reset_sequencer (
    .aclk, .aresetn, .platform_reset_n, .power_on_n, .switch_mode_straps,
    .reset_halt, .master_smbus_slow_strap, .slave_smbus_addr_straps,
    .test_mode, .hot_reset_ts1, .dl_down, .ee_wr_valid, .ee_wr_addr,
    .ee_wr_data, .ee_done, .ee_error, .ee_error_code, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .pll_serdes_rst_n(), .link_train_en(), .stack_rst_n(), .quasi_reset(),
    .core_rst_n(), .slave_smbus_rst_n(), .slave_smbus_addr(),
    .master_smbus_rst_n(), .master_smbus_slow(), .ee_load_start,
    .low_latency, .hot_reset_ts1_out(), .port_retrain, .sequence_state);
  ee_loader_model i_ee_loader_model (.aclk, .aresetn, .start(ee_load_start),
    .fail, .slow, .wr_valid(ee_wr_valid), .wr_addr(ee_wr_addr),
    .wr_data(ee_wr_data), .done(ee_done), .error(ee_error),
    .code(ee_error_code));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report();
    $display("checks=%0d errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  // Handshakes are judged at the falling edge so that the values seen are
  // the ones the next rising edge samples, free of update races.
  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    logic ah, wh;
    ah = 0;
    wh = 0;
    @(posedge aclk);
    s_axi_awaddr <= {20'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      ah = ah | s_axi_awready;
      wh = wh | s_axi_wready;
      bst = s_axi_bvalid;
      st7 = sequence_state === 3'h7;
      @(posedge aclk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
    end while (bst !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [11:0] a);
    logic ah;
    ah = 0;
    @(posedge aclk);
    s_axi_araddr <= {20'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ah = ah | s_axi_arready;
      bst = s_axi_rvalid;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      if (ah) s_axi_arvalid <= 1'b0;
    end while (bst !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask : axr
  task automatic wst(input logic [2:0] s, input bit eq);
    while ((sequence_state === s) != eq) @(negedge aclk);
  endtask : wst
  task automatic prst(input logic [2:0] md);
    @(posedge aclk);
    switch_mode_straps <= md;
    slave_smbus_addr_straps <= 4'($urandom);
    master_smbus_slow_strap <= 1'($urandom);
    platform_reset_n <= 1'b0;
    repeat (6) @(posedge aclk);
    platform_reset_n <= 1'b1;
  endtask : prst
  task automatic pulse(input bit dl);
    @(posedge aclk);
    dl_down <= dl;
    hot_reset_ts1 <= !dl;
    repeat (4) @(posedge aclk);
    dl_down <= 1'b0;
    hot_reset_ts1 <= 1'b0;
  endtask : pulse
  initial forever #25 aclk = ~aclk;
  always @(negedge aclk) begin
    cyc++;
    if (ee_load_start === 1'b1) n_ee++;
    if ((|port_retrain) === 1'b1) n_rt++;
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end
  initial begin
    void'($urandom(32'h2260b19a));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    power_on_n <= 1'b1;
    for (m = 0; m < 4; m++) begin
      k = n_ee;
      slow <= m[1];
      prst(m[2:0]);
      wst(3'h7, 1);
      axr(rst_seq_pkg::ADDR_STAT);
      chk(rd & 32'h1ff, {23'h0, slave_smbus_addr_straps,
        master_smbus_slow_strap, 1'b0, m[2:0]});
      chk(low_latency, m[1]);
      chk(rd[14], m == 0);
      chk(n_ee - k, m[0]);
      $display("mode %0d done", m);
    end
    exp_rt = 2;
    axr(rst_seq_pkg::ADDR_SMB);
    chk(rd[1:0], 2'h1);
    axr(12'h100);
    chk(rr, rst_seq_pkg::RESP_SLVERR);
    switch_mode_straps <= 3'h0;
    axw(rst_seq_pkg::ADDR_CTRL, 32'h1);
    chk(st7, 1'b1);
    wst(3'h7, 0);
    wst(3'h7, 1);
    exp_rt++;
    axr(rst_seq_pkg::ADDR_STAT);
    chk({rd[14], rd[2:0]}, 4'h3);
    axr(rst_seq_pkg::ADDR_SCRATCH);
    chk(rd, 32'ha5);
    $display("software reset done");
    reset_halt <= 1'b1;
    prst(3'h0);
    wst(3'h6, 1);
    axr(rst_seq_pkg::ADDR_STAT);
    chk(rd[3], 1'b1);
    reset_halt <= 1'b0;
    axw(rst_seq_pkg::ADDR_CTRL, 32'h0);
    wst(3'h7, 1);
    fail <= 1'b1;
    prst(3'h1);
    wst(3'h6, 1);
    axr(rst_seq_pkg::ADDR_SMB);
    chk(rd[9:0], 10'h0f3);
    axr(rst_seq_pkg::ADDR_CTRL);
    chk(rd[2], 1'b1);
    fail <= 1'b0;
    axw(rst_seq_pkg::ADDR_CTRL, 32'h8);
    wst(3'h7, 1);
    $display("halt tests done");
    scr = $urandom;
    axw(rst_seq_pkg::ADDR_SCRATCH, scr);
    axr(rst_seq_pkg::ADDR_SCRATCH);
    chk(rd, scr);
    k = n_ee;
    pulse(1);
    repeat (40) @(negedge aclk);
    chk(sequence_state, 3'h7);
    pulse(0);
    wst(3'h7, 0);
    axr(rst_seq_pkg::ADDR_SCRATCH);
    chk(rd, 32'h0);
    axw(rst_seq_pkg::ADDR_CTRL, 32'h0);
    wst(3'h7, 1);
    exp_rt++;
    axr(rst_seq_pkg::ADDR_SCRATCH);
    chk(rd, 32'ha5);
    chk(n_ee - k, 1);
    axr(rst_seq_pkg::ADDR_CTRL);
    chk(rd[3], 1'b1);
    axw(rst_seq_pkg::ADDR_CTRL, 32'h1a);
    chk(st7, 1'b1);
    wst(3'h7, 0);
    wst(3'h7, 1);
    axr(rst_seq_pkg::ADDR_SCRATCH);
    chk(rd, 32'h0);
    chk(n_ee - k, 1);
    axw(rst_seq_pkg::ADDR_CTRL, 32'h0);
    pulse(1);
    wst(3'h7, 0);
    wst(3'h7, 1);
    exp_rt++;
    chk(n_ee - k, 2);
    chk(n_rt, exp_rt);
    $display("hot reset tests done");
    final_report();
  end
endmodule : test_switch_reset_sequencer
